// >>> tmi_defines.svh
`ifndef TMI_DEFINES_SVH
`define TMI_DEFINES_SVH

// ==========================================================================
// Register byte offsets on the Wishbone slave
`define TMI_OFS_MASK 4'h0
`define TMI_OFS_FLAGS 4'h4
`define TMI_OFS_CFG 4'h8

// ==========================================================================
// Reset values
`define TMI_MASK_RST 8'h00
`define TMI_FLAGS_RST 8'h00
`define TMI_CFG_RST 5'h00
`define TMI_WORD_ZERO 32'h0000_0000
`define TMI_REQ_RST 8'h00

// ==========================================================================
// Interrupt sources sharing the mask, flag and request vectors
`define TMI_NUM_SRC 8

// ==========================================================================
// Bit positions shared by mask, flags and request vector
`define TMI_BIT_T8B_CMP 7
`define TMI_BIT_T8B_OVF 6
`define TMI_BIT_CAP 5
`define TMI_BIT_CMP_A 4
`define TMI_BIT_CMP_B 3
`define TMI_BIT_OVF 2
`define TMI_BIT_T8A_CMP 1
`define TMI_BIT_T8A_OVF 0

// ==========================================================================
// Configuration register fields
`define TMI_CFG_MODE_LSB 0
`define TMI_CFG_MODE_MSB 3
`define TMI_CFG_EDGE_BIT 4

// ==========================================================================
// Waveform mode codes
`define TMI_WGM_NORMAL 4'h0
`define TMI_WGM_PC8 4'h1
`define TMI_WGM_PC9 4'h2
`define TMI_WGM_PC10 4'h3
`define TMI_WGM_CTC_A 4'h4
`define TMI_WGM_FAST8 4'h5
`define TMI_WGM_FAST9 4'h6
`define TMI_WGM_FAST10 4'h7
`define TMI_WGM_PFC_CAP 4'h8
`define TMI_WGM_PFC_A 4'h9
`define TMI_WGM_PC_CAP 4'hA
`define TMI_WGM_PC_A 4'hB
`define TMI_WGM_CTC_CAP 4'hC
`define TMI_WGM_RSVD 4'hD
`define TMI_WGM_FAST_CAP 4'hE
`define TMI_WGM_FAST_A 4'hF

`endif

// >>> tmi_pkg.sv
`default_nettype none

// ==========================================================================
// Shared types
package tmi_pkg;

  typedef logic [7:0] tmi_byte_t;

  // Same-clock strobes from the timer units, one cycle each
  typedef struct packed {
    logic t8b_cmp;
    logic t8b_ovf;
    logic t16_match_a;
    logic t16_match_b;
    logic t16_force_cmp_a;
    logic t16_force_cmp_b;
    logic t16_at_top;
    logic t16_at_max;
    logic t16_at_bottom;
    logic t8a_cmp;
    logic t8a_ovf;
  } tmi_evt_s;

endpackage : tmi_pkg

`default_nettype wire

// >>> tmi_capture_edge.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Capture pin synchroniser and edge selector
module tmi_capture_edge (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic t16_capture_pin_i,
  input wire logic t16_capture_edge_sel_i,
  output logic capture_evt_o
);

  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic evt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= t16_capture_pin_i;
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 1'b0;
      evt_q <= 1'b0;
    end else begin
      prev_q <= sync_q;
      // Rising edge when select is one, falling edge when zero
      evt_q <= t16_capture_edge_sel_i ? (sync_q & ~prev_q) : (~sync_q & prev_q);
    end
  end

  assign capture_evt_o = evt_q;

  edge_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (prev_q != sync_q) && (sync_q == t16_capture_edge_sel_i) |=> capture_evt_o)
    else $error("selected capture edge did not produce an event");

endmodule : tmi_capture_edge

`default_nettype wire

// >>> tmi_irq_flags.sv
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "tmi_defines.svh"

// How it works
// - Capture request needs enable bit 5, global, flag
// - Compare-A request needs bit 4, global, flag
// - Compare-B request needs bit 3, global, flag
// - Overflow request needs bit 2, global, flag
// - Capture pin event sets capture flag bit 5
// - Capture-as-top modes set capture flag at top
// - Capture flag cleared by vector or one-write
// - Compare-A match sets flag bit 4 next cycle
// - Forced compare strobes never set compare flags
// - Compare-A flag cleared by vector or one-write
// - Compare-B match sets flag bit 3 next cycle
// - Compare-B flag cleared by vector or one-write
// - Normal and clear-on-match set overflow on overflow
// - Overflow flag cleared by vector or one-write
// - Mask holds eight enables, read/write, reset zero
// - Flags mirror mask layout, reset zero
// - Overflow at MAX, TOP or BOTTOM per mode
// - Capture edge falling when select zero, else rising

module tmi_irq_flags #(
  parameter int unsigned NUM_SRC = `TMI_NUM_SRC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // CPU interrupt logic
  input wire logic global_irq_en_i,
  input wire logic [7:0] irq_ack_i,
  output logic [7:0] irq_req_o,
  // Timer units
  input wire tmi_pkg::tmi_evt_s evt_i,
  input wire logic t16_capture_pin_i
);

  // ========================================================================
  // Registers and wires
  logic ack_q;
  logic [31:0] dat_q;
  tmi_pkg::tmi_byte_t mask_q;
  tmi_pkg::tmi_byte_t flags_q;
  tmi_pkg::tmi_byte_t flags_d;
  tmi_pkg::tmi_byte_t set_vec;
  tmi_pkg::tmi_byte_t clr_vec;
  tmi_pkg::tmi_byte_t req_q;
  logic [4:0] cfg_q;
  logic [3:0] t16_waveform_mode;
  logic t16_capture_edge_sel;
  logic pin_evt;
  logic cap_set;
  logic ovf_set;
  logic cap_is_top;
  logic req_hit;
  logic wr_en;
  logic wr_lane0;

  assign t16_waveform_mode = cfg_q[`TMI_CFG_MODE_MSB:`TMI_CFG_MODE_LSB];
  assign t16_capture_edge_sel = cfg_q[`TMI_CFG_EDGE_BIT];

  // ========================================================================
  // Elaboration checks
  // Every source needs one bit in each of the byte-wide registers
  if (NUM_SRC != `TMI_NUM_SRC) begin : g_bad_src
    $error("NUM_SRC must equal the width of the mask and flag registers");
  end

  // ========================================================================
  // Wishbone slave
  assign req_hit = wb_cyc_i & wb_stb_i;
  // Write lands on the edge where the master sees ack
  assign wr_en = req_hit & wb_we_i & ack_q;
  assign wr_lane0 = wr_en & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req_hit & ~ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= `TMI_WORD_ZERO;
    end else if (req_hit & ~ack_q) begin
      unique case (wb_adr_i)
        `TMI_OFS_MASK: dat_q <= {24'h00_0000, mask_q};
        `TMI_OFS_FLAGS: dat_q <= {24'h00_0000, flags_q};
        `TMI_OFS_CFG: dat_q <= {27'h000_0000, cfg_q};
        default: dat_q <= `TMI_WORD_ZERO;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ========================================================================
  // Mask and configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= `TMI_MASK_RST;
    end else if (wr_lane0 && wb_adr_i == `TMI_OFS_MASK) begin
      mask_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= `TMI_CFG_RST;
    end else if (wr_lane0 && wb_adr_i == `TMI_OFS_CFG) begin
      cfg_q <= wb_dat_i[4:0];
    end
  end

  // ========================================================================
  // Capture front end
  tmi_capture_edge u_capture_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .t16_capture_pin_i(t16_capture_pin_i),
    .t16_capture_edge_sel_i(t16_capture_edge_sel),
    .capture_evt_o(pin_evt)
  );

  // ========================================================================
  // Set conditions
  always_comb begin
    cap_is_top = 1'b0;
    ovf_set = 1'b0;
    unique case (t16_waveform_mode)
      `TMI_WGM_NORMAL, `TMI_WGM_CTC_A: begin
        ovf_set = evt_i.t16_at_max;
      end
      `TMI_WGM_CTC_CAP: begin
        cap_is_top = 1'b1;
        ovf_set = evt_i.t16_at_max;
      end
      `TMI_WGM_FAST8, `TMI_WGM_FAST9, `TMI_WGM_FAST10, `TMI_WGM_FAST_A: begin
        ovf_set = evt_i.t16_at_top;
      end
      `TMI_WGM_FAST_CAP: begin
        cap_is_top = 1'b1;
        ovf_set = evt_i.t16_at_top;
      end
      `TMI_WGM_PC8, `TMI_WGM_PC9, `TMI_WGM_PC10, `TMI_WGM_PFC_A,
      `TMI_WGM_PC_A: begin
        ovf_set = evt_i.t16_at_bottom;
      end
      `TMI_WGM_PFC_CAP, `TMI_WGM_PC_CAP: begin
        cap_is_top = 1'b1;
        ovf_set = evt_i.t16_at_bottom;
      end
      `TMI_WGM_RSVD: begin
        ovf_set = 1'b0;
      end
    endcase
  end

  // Pin is disconnected while the capture register serves as top
  assign cap_set = cap_is_top ? evt_i.t16_at_top : pin_evt;

  always_comb begin
    set_vec = 8'h00;
    set_vec[`TMI_BIT_T8B_CMP] = evt_i.t8b_cmp;
    set_vec[`TMI_BIT_T8B_OVF] = evt_i.t8b_ovf;
    set_vec[`TMI_BIT_CAP] = cap_set;
    // A forced strobe acts on the output only
    set_vec[`TMI_BIT_CMP_A] = evt_i.t16_match_a & ~evt_i.t16_force_cmp_a;
    set_vec[`TMI_BIT_CMP_B] = evt_i.t16_match_b & ~evt_i.t16_force_cmp_b;
    set_vec[`TMI_BIT_OVF] = ovf_set;
    set_vec[`TMI_BIT_T8A_CMP] = evt_i.t8a_cmp;
    set_vec[`TMI_BIT_T8A_OVF] = evt_i.t8a_ovf;
  end

  // ========================================================================
  // Flag bits
  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_flag
      // Vector acknowledge or a written one clears; a written zero does nothing
      assign clr_vec[i] = irq_ack_i[i]
        | (wr_lane0 & (wb_adr_i == `TMI_OFS_FLAGS) & wb_dat_i[i]);
      assign flags_d[i] = set_vec[i] | (flags_q[i] & ~clr_vec[i]);
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= `TMI_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ========================================================================
  // Requests to the CPU, one per source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= `TMI_REQ_RST;
    end else begin
      req_q <= flags_q & mask_q & {8{global_irq_en_i}};
    end
  end

  assign irq_req_o = req_q;

  // ========================================================================
  // Checks
  cap_req_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_req_o[`TMI_BIT_CAP] |->
      $past(flags_q[`TMI_BIT_CAP] & mask_q[`TMI_BIT_CAP] & global_irq_en_i))
    else $error("capture request without flag, enable and global enable");

  cmp_a_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
    flags_q[`TMI_BIT_CMP_A] && mask_q[`TMI_BIT_CMP_A] && global_irq_en_i
      |=> irq_req_o[`TMI_BIT_CMP_A])
    else $error("compare-A request not raised");

  cmp_b_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !mask_q[`TMI_BIT_CMP_B] |=> !irq_req_o[`TMI_BIT_CMP_B])
    else $error("compare-B request raised while masked");

  ovf_req_global_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !global_irq_en_i |=> irq_req_o == 8'h00)
    else $error("request raised with global enable off");

  cmp_a_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    evt_i.t16_match_a && !evt_i.t16_force_cmp_a |=> flags_q[`TMI_BIT_CMP_A])
    else $error("compare-A match did not set its flag next cycle");

  cmp_b_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    evt_i.t16_match_b && !evt_i.t16_force_cmp_b |=> flags_q[`TMI_BIT_CMP_B])
    else $error("compare-B match did not set its flag next cycle");

  force_no_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    evt_i.t16_force_cmp_a && !flags_q[`TMI_BIT_CMP_A] |=> !flags_q[`TMI_BIT_CMP_A])
    else $error("forced compare set the compare-A flag");

  cap_top_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    t16_waveform_mode == `TMI_WGM_FAST_CAP && evt_i.t16_at_top
      |=> flags_q[`TMI_BIT_CAP])
    else $error("capture flag not set at top in capture-top mode");

  ovf_normal_a: assert property (@(posedge clk_i) disable iff (rst_i)
    t16_waveform_mode == `TMI_WGM_NORMAL && evt_i.t16_at_max |=> flags_q[`TMI_BIT_OVF])
    else $error("overflow flag not set at max in normal mode");

  ovf_pc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    t16_waveform_mode == `TMI_WGM_PC_A && evt_i.t16_at_bottom
      |=> flags_q[`TMI_BIT_OVF])
    else $error("overflow flag not set at bottom in phase correct mode");

  ack_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_ack_i[`TMI_BIT_OVF] && !ovf_set |=> !flags_q[`TMI_BIT_OVF])
    else $error("overflow flag survived its acknowledge");

  w1c_cap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_lane0 && wb_adr_i == `TMI_OFS_FLAGS && wb_dat_i[`TMI_BIT_CAP] && !cap_set
      |=> !flags_q[`TMI_BIT_CAP])
    else $error("capture flag not cleared by a written one");

  set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_ack_i[`TMI_BIT_CMP_A] && set_vec[`TMI_BIT_CMP_A] |=> flags_q[`TMI_BIT_CMP_A])
    else $error("clear won over a simultaneous set");

  mask_reset_a: assert property (@(posedge clk_i)
    rst_i |=> mask_q == 8'h00 && flags_q == 8'h00)
    else $error("mask or flags not zero after reset");

  ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held for more than one cycle");

  w1c_set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_lane0 && wb_adr_i == `TMI_OFS_FLAGS && wb_dat_i[`TMI_BIT_CMP_A]
      && set_vec[`TMI_BIT_CMP_A]
      |=> flags_q[`TMI_BIT_CMP_A])
    else $error("written one won over a simultaneous compare-A set");

  force_b_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    evt_i.t16_force_cmp_b && !flags_q[`TMI_BIT_CMP_B] |=> !flags_q[`TMI_BIT_CMP_B])
    else $error("forced compare set the compare-B flag");

  ovf_fast_top_a: assert property (@(posedge clk_i) disable iff (rst_i)
    t16_waveform_mode == `TMI_WGM_FAST8 && evt_i.t16_at_top |=> flags_q[`TMI_BIT_OVF])
    else $error("overflow flag not set at top in fast mode");

  cap_pin_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_evt && !cap_is_top |=> flags_q[`TMI_BIT_CAP])
    else $error("capture pin event did not set the capture flag");

  cmp_a_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_ack_i[`TMI_BIT_CMP_A] && !set_vec[`TMI_BIT_CMP_A]
      |=> !flags_q[`TMI_BIT_CMP_A])
    else $error("compare-A flag survived its acknowledge");

endmodule : tmi_irq_flags

`default_nettype wire

// >>> tmi_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// CPU stand-in: executes one vector at a time, lowest source first
module tmi_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [7:0] irq_req_i,
  output logic [7:0] irq_ack_o
);
  logic [7:0] ack_q;
  logic [1:0] wait_q;
  // Waiting lets the served request fall before the next pick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 8'h00;
      wait_q <= 2'h0;
    end else if (wait_q != 2'h0) begin
      ack_q <= 8'h00;
      wait_q <= wait_q - 2'h1;
    end else if (run_i && (irq_req_i != 8'h00)) begin
      ack_q <= irq_req_i & ~(irq_req_i - 8'h01);
      wait_q <= 2'h3;
    end else begin
      ack_q <= 8'h00;
    end
  end
  assign irq_ack_o = ack_q;
endmodule : tmi_cpu_model
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "tmi_defines.svh"

// ==========================================================================
// Testbench
module tb_top;
  logic clk_i, rst_i, cyc, stb, we, ack, gie, run, pin;
  logic [3:0] adr;
  logic [31:0] dw, dr, rd;
  logic [7:0] iack, ireq;
  tmi_pkg::tmi_evt_s evt;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  tmi_irq_flags DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .global_irq_en_i(gie), .irq_ack_i(iack), .irq_req_o(ireq),
    .evt_i(evt), .t16_capture_pin_i(pin));
  tmi_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .irq_req_i(ireq),
    .irq_ack_o(iack));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Cuts a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, {24'h00_0000, exp});
  endtask : rchk

  task automatic pulse(input logic [10:0] e);
    @(posedge clk_i);
    evt <= tmi_pkg::tmi_evt_s'(e);
    @(posedge clk_i);
    evt <= '0;
  endtask : pulse

  task automatic ev_case(input logic [3:0] m, input logic [10:0] e, input logic [7:0] exp);
    bus(1'b1, `TMI_OFS_CFG, {28'h000_0000, m});
    pulse(e);
    rchk(`TMI_OFS_FLAGS, exp);
    bus(1'b1, `TMI_OFS_FLAGS, 32'h0000_00FF);
    rchk(`TMI_OFS_FLAGS, 8'h00);
  endtask : ev_case

  task automatic t_regs;
    rchk(`TMI_OFS_MASK, 8'h00);
    rchk(`TMI_OFS_FLAGS, 8'h00);
    rchk(4'hC, 8'h00);
    bus(1'b1, `TMI_OFS_CFG, 32'h0000_001F);
    rchk(`TMI_OFS_CFG, 8'h1F);
    bus(1'b1, `TMI_OFS_MASK, 32'h0000_00A5);
    rchk(`TMI_OFS_MASK, 8'hA5);
    bus(1'b1, `TMI_OFS_MASK, 32'h0000_005A);
    rchk(`TMI_OFS_MASK, 8'h5A);
    bus(1'b1, `TMI_OFS_MASK, 32'h0000_0000);
  endtask : t_regs

  task automatic t_events;
    logic [7:0] ex [11] = '{8'h01, 8'h02, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h08,
      8'h10, 8'h40, 8'h80};
    for (int i = 0; i < 11; i++) ev_case(4'h0, 11'h001 << i, ex[i]);
  endtask : t_events

  task automatic t_modes;
    logic [3:0] m [10] = '{4'h4, 4'h5, 4'h8, 4'h8, 4'hC, 4'hC, 4'hD, 4'hE, 4'hA, 4'h1};
    logic [10:0] e [10] = '{11'h008, 11'h010, 11'h004, 11'h010, 11'h008, 11'h010,
      11'h008, 11'h010, 11'h010, 11'h004};
    logic [7:0] ex [10] = '{8'h04, 8'h04, 8'h04, 8'h20, 8'h04, 8'h20, 8'h00, 8'h24,
      8'h20, 8'h04};
    for (int i = 0; i < 10; i++) ev_case(m[i], e[i], ex[i]);
  endtask : t_modes

  task automatic t_w1c;
    bus(1'b1, `TMI_OFS_CFG, 32'h0000_0000);
    pulse(11'h180);
    bus(1'b1, `TMI_OFS_FLAGS, 32'h0000_0000);
    rchk(`TMI_OFS_FLAGS, 8'h18);
    bus(1'b1, `TMI_OFS_FLAGS, 32'h0000_0010);
    rchk(`TMI_OFS_FLAGS, 8'h08);
    bus(1'b1, `TMI_OFS_FLAGS, 32'h0000_0008);
    rchk(`TMI_OFS_FLAGS, 8'h00);
  endtask : t_w1c

  task automatic t_pin;
    logic [7:0] c [5] = '{8'h00, 8'h00, 8'h10, 8'h10, 8'h0C};
    logic p [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [7:0] ex [5] = '{8'h20, 8'h00, 8'h00, 8'h20, 8'h00};
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, `TMI_OFS_CFG, {24'h00_0000, c[i]});
      pin <= p[i];
      repeat (8) @(posedge clk_i);
      rchk(`TMI_OFS_FLAGS, ex[i]);
      bus(1'b1, `TMI_OFS_FLAGS, 32'h0000_00FF);
    end
  endtask : t_pin

  task automatic t_req;
    logic [7:0] m [4] = '{8'h20, 8'h10, 8'h08, 8'h04};
    bus(1'b1, `TMI_OFS_CFG, 32'h0000_0000);
    bus(1'b1, `TMI_OFS_MASK, 32'h0000_0010);
    gie <= 1'b1;
    pulse(11'h100);
    @(posedge clk_i) chk(ireq, 8'h00);
    @(posedge clk_i) chk(ireq, 8'h10);
    bus(1'b1, `TMI_OFS_CFG, 32'h0000_000E);
    pulse(11'h793);
    rchk(`TMI_OFS_FLAGS, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `TMI_OFS_MASK, {24'h00_0000, m[i]});
      gie <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(ireq, 8'h00);
      gie <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk(ireq, m[i]);
    end
    bus(1'b1, `TMI_OFS_MASK, 32'h0000_00FF);
    run <= 1'b1;
    repeat (60) @(posedge clk_i);
    rchk(`TMI_OFS_FLAGS, 8'h00);
    chk(ireq, 8'h00);
    run <= 1'b0;
  endtask : t_req

  // Set meets a vector clear, then a written-one clear, in one cycle
  task automatic t_race;
    bus(1'b1, `TMI_OFS_MASK, 32'h0000_0010);
    run <= 1'b1;
    pulse(11'h100);
    do @(posedge clk_i); while (ireq[4] !== 1'b1);
    evt <= tmi_pkg::tmi_evt_s'(11'h100);
    @(posedge clk_i);
    evt <= '0;
    run <= 1'b0;
    rchk(`TMI_OFS_FLAGS, 8'h10);
    fork
      bus(1'b1, `TMI_OFS_FLAGS, 32'h0000_0010);
      begin
        repeat (2) @(posedge clk_i);
        evt <= tmi_pkg::tmi_evt_s'(11'h100);
        @(posedge clk_i);
        evt <= '0;
      end
    join
    rchk(`TMI_OFS_FLAGS, 8'h10);
    bus(1'b1, `TMI_OFS_FLAGS, 32'h0000_0010);
    rchk(`TMI_OFS_FLAGS, 8'h00);
  endtask : t_race

  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, gie, run} = 5'h00;
    pin = 1'b1;
    adr = 4'h0;
    dw = 32'h0000_0000;
    evt = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_events();
    t_modes();
    t_w1c();
    t_pin();
    t_req();
    t_race();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
